/* logic/dcs_spacing_tracker.sv */
/*
  device-side command spacing tracker for a ddr2 sdram: decodes commands,
  follows the power state, holds the mode_config_word and flags activates
  that arrive inside the device's guaranteed acceptance spacing.
  assumes the command pins arrive from outside and are resynchronised here;
  the controller keeps its own spacing obligations.
*/
`timescale 1ns/1ps
`default_nettype none
module dcs_spacing_tracker (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_cke,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_ras_n,
  input  wire logic                    i_cas_n,
  input  wire logic                    i_we_n,
  input  wire logic [dcs_pkg::BA_W-1:0]   i_ba,
  input  wire logic [dcs_pkg::ADDR_W-1:0] i_addr,
  output logic [dcs_pkg::ADDR_W-1:0]      o_mode_config_word,
  output logic                            o_strobe_single_ended,
  output logic [2:0]                      o_write_recovery_clocks,
  output logic [1:0]                      o_power_state,
  output logic                            o_clk_change_ok,
  output logic                            o_act_ready,
  output logic                            o_spacing_violation
);
  import dcs_pkg::*;

  // timing of the pins, as this block sees them:
  //  - every pin passes two flops before decode reads it
  //  - a command sampled at edge e is decoded at e+2
  //  - cke stage two and its delayed copy decide the power edges
  //  - a command counts only if cke was high on both of those samples
  //
  // power state handling:
  //  - cke falling with refresh on the pins enters self refresh
  //  - cke falling with every bank closed enters precharge power-down
  //  - cke falling with a bank open enters active power-down
  //  - cke rising from any low-power state returns to active
  //  - the exit edge loads the exit counter, so an activate one edge
  //    later is flagged and one two edges later is taken
  //
  // why violations are flagged rather than blocked:
  //  - a real device cannot push back on its controller, so the
  //    best it can do is report the command that came too early
  //  - a refused activate leaves the bank map unchanged, which keeps the
  //    bank map honest for later commands
  //
  // counter behaviour:
  //  - every counter counts clock edges, never elapsed time, so a
  //    jittery clock still gives the controller its full count
  //  - precharge loads the rounded precharge count minus one, since
  //    the load edge itself is the first counted edge
  //  - counters stop at zero and are never reloaded by a refused
  //    command
  //
  // limitations:
  //  - reads and writes are not tracked; their spacing stays with the
  //    controller
  //  - write recovery is passed out raw from the mode word, with no
  //    offset applied
  //  - a clock frequency change is only reported as allowed, not
  //    detected

  typedef struct packed {
    logic                         cke_s1;
    logic                         cke_s2;
    logic                         cke_prev;
    logic [3:0]                   cmd_s1;
    logic [3:0]                   cmd_s2;
    logic [BA_W-1:0]              ba_s1;
    logic [BA_W-1:0]              ba_s2;
    logic [ADDR_W-1:0]            addr_s1;
    logic [ADDR_W-1:0]            addr_s2;
    dcs_state_t                   pstate;
    logic [ADDR_W-1:0]            mode;
    logic [BANKS-1:0]             open;
    logic [BANKS-1:0][CNT_W-1:0]  rp_cnt;
    logic [CNT_W-1:0]             xp_cnt;
    logic                         viol;
  } dcs_reg_t;

  dcs_reg_t st_q;
  dcs_reg_t st_d;

  // next-state logic for the whole block
  always_comb begin
    logic       cmd_valid;
    logic       cke_fall;
    logic       cke_rise;
    dcs_cmd_t   cmd;
    logic [BA_W-1:0] bank;
    cmd_valid = 1'b0;
    cke_fall  = 1'b0;
    cke_rise  = 1'b0;
    cmd       = DCS_CMD_NOP;
    bank      = st_q.ba_s2;
    st_d      = st_q;

    // two-stage resynchronisers; only stage two is read by logic
    st_d.cke_s1   = i_cke;
    st_d.cke_s2   = st_q.cke_s1;
    st_d.cmd_s1   = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    st_d.cmd_s2   = st_q.cmd_s1;
    st_d.ba_s1    = i_ba;
    st_d.ba_s2    = st_q.ba_s1;
    st_d.addr_s1  = i_addr;
    st_d.addr_s2  = st_q.addr_s1;
    st_d.cke_prev = st_q.cke_s2;
    st_d.viol     = 1'b0;

    cmd       = dcs_cmd_t'(st_q.cmd_s2);
    cmd_valid = st_q.cke_prev & st_q.cke_s2;
    cke_fall  = st_q.cke_prev & ~st_q.cke_s2;
    cke_rise  = ~st_q.cke_prev & st_q.cke_s2;

    // counters drop by one on every clock edge, not by elapsed time
    for (int b = 0; b < BANKS; b++) begin
      if (st_q.rp_cnt[b] != CNT_ZERO) begin
        st_d.rp_cnt[b] = st_q.rp_cnt[b] - CNT_ONE;
      end
    end
    if (st_q.xp_cnt != CNT_ZERO) begin
      st_d.xp_cnt = st_q.xp_cnt - CNT_ONE;
    end

    // power state follows cke edges; refresh with cke low means self refresh
    case (st_q.pstate)
      DCS_ST_ACTIVE: begin
        if (cke_fall) begin
          if (cmd == DCS_CMD_REF && st_q.cmd_s2[3] == 1'b0) begin
            st_d.pstate = DCS_ST_SELF_REF;
          end else if (st_q.open == '0) begin
            st_d.pstate = DCS_ST_PRE_PD;
          end else begin
            st_d.pstate = DCS_ST_ACT_PD;
          end
        end
      end
      DCS_ST_PRE_PD, DCS_ST_ACT_PD, DCS_ST_SELF_REF: begin
        if (cke_rise) begin
          st_d.pstate = DCS_ST_ACTIVE;
          // exit registered at tm, activate allowed at tm+2
          st_d.xp_cnt = POWERDOWN_EXIT_DELAY - CNT_ONE;
        end
      end
      default: begin
        st_d.pstate = DCS_ST_ACTIVE;
      end
    endcase

    // command decode while cke has been high on both edges
    if (cmd_valid && st_q.pstate == DCS_ST_ACTIVE) begin
      case (cmd)
        DCS_CMD_MODE: begin
          if (st_q.ba_s2 == BA_MODE) begin
            st_d.mode = st_q.addr_s2;
          end
        end
        DCS_CMD_PRE: begin
          for (int b = 0; b < BANKS; b++) begin
            if (st_q.addr_s2[AUTO_PRE_BIT] || bank == BA_W'(b)) begin
              st_d.open[b] = 1'b0;
              // spacing in whole cycles, rounded up from nanoseconds
              st_d.rp_cnt[b] = TRP_CYC - CNT_ONE;
            end
          end
        end
        DCS_CMD_ACT: begin
          // an activate inside an accepted spacing is flagged, not obeyed
          if (st_q.xp_cnt != CNT_ZERO ||
              st_q.rp_cnt[bank] != CNT_ZERO ||
              st_q.open[bank]) begin
            st_d.viol = 1'b1;
          end else begin
            st_d.open[bank] = 1'b1;
          end
        end
        default: begin
          st_d.viol = 1'b0;
        end
      endcase
    end

    // synchronous active-low reset to constants only
    if (!i_rst_n) begin
      st_d        = '0;
      st_d.pstate = DCS_ST_ACTIVE;
      st_d.mode   = MODE_RESET;
    end
  end

  // single register bank for all state
  always_ff @(posedge i_clk) begin
    st_q <= st_d;
  end

  // outputs from flops, through decode only for the ready and clock-change flags
  assign o_mode_config_word      = st_q.mode;
  assign o_strobe_single_ended   = st_q.mode[MODE_STROBE_BIT];
  assign o_write_recovery_clocks = st_q.mode[MODE_WR_MSB:MODE_WR_LSB];
  assign o_power_state           = st_q.pstate;
  // frequency change only in self refresh or precharge power-down
  assign o_clk_change_ok = (st_q.pstate == DCS_ST_SELF_REF) ||
                           (st_q.pstate == DCS_ST_PRE_PD);
  assign o_act_ready         = (st_q.pstate == DCS_ST_ACTIVE) &&
                               (st_q.xp_cnt == CNT_ZERO);
  assign o_spacing_violation = st_q.viol;

endmodule
`default_nettype wire

/* shared/dcs_pkg.sv */
/*
  constants, encodings and types shared by the ddr2 command spacing tracker.
  assumes a single clock domain running at the counted clock rate.
*/
package dcs_pkg;

  // clock and nanosecond timing figures
  localparam int unsigned CLK_PERIOD_PS = 100000;   // 10 mhz counted clock
  localparam int unsigned TRP_PS        = 15000;    // precharge period, 15 ns

  // round a time up to whole counted clock cycles, never below one
  function automatic int unsigned dcs_ceil_cycles(input int unsigned t_ps);
    int unsigned n;
    n = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n == 0) ? 1 : n;
  endfunction

  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] TRP_CYC =
    CNT_W'(dcs_ceil_cycles(TRP_PS));
  // powerdown_exit_delay is given directly in counted clock cycles
  localparam logic [CNT_W-1:0] POWERDOWN_EXIT_DELAY = 4'h2;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // pin widths
  localparam int unsigned BANKS  = 4;
  localparam int unsigned BA_W   = 2;
  localparam int unsigned ADDR_W = 14;

  // mode_config_word field positions
  localparam int unsigned MODE_STROBE_BIT = 10;   // 1 = single-ended strobe
  localparam int unsigned MODE_WR_LSB     = 9;
  localparam int unsigned MODE_WR_MSB     = 11;
  localparam int unsigned AUTO_PRE_BIT    = 10;   // a10: precharge all banks
  localparam logic [ADDR_W-1:0] MODE_RESET = 14'h0000;
  localparam logic [BA_W-1:0]   BA_MODE    = 2'h0;

  // command codes {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DCS_CMD_MODE  = 4'h0,
    DCS_CMD_REF   = 4'h1,
    DCS_CMD_PRE   = 4'h2,
    DCS_CMD_ACT   = 4'h3,
    DCS_CMD_WRITE = 4'h4,
    DCS_CMD_READ  = 4'h5,
    DCS_CMD_NOP   = 4'h7
  } dcs_cmd_t;

  // power state, gray coded around the usual path
  typedef enum logic [1:0] {
    DCS_ST_ACTIVE   = 2'h0,
    DCS_ST_PRE_PD   = 2'h1,
    DCS_ST_ACT_PD   = 2'h3,
    DCS_ST_SELF_REF = 2'h2
  } dcs_state_t;

endpackage

/* testbench/dcs_ctrl_model.sv */
/* controller-side clock enable pacer for the spacing tracker bench.
   assumes the bench asks for cke levels at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_model (
  input  wire logic i_clk,
  input  wire logic i_cke,
  output logic      o_cke
);
  logic       held_q = 1'b1;
  logic [1:0] gap_q  = 2'h3;
  // count rising edges since the last level change, saturating at three
  always @(posedge i_clk) begin
    held_q <= o_cke;
    gap_q  <= (o_cke !== held_q) ? 2'h1 :
              ((gap_q == 2'h3) ? gap_q : gap_q + 2'h1);
  end
  // a request to move early is held back, never sent as a glitch
  assign o_cke = (gap_q == 2'h3) ? i_cke : held_q;
endmodule
`default_nettype wire

/* testbench/dcs_spacing_tracker_assertions.sv */
/* concurrent checks on the spacing tracker ports.
   assumes command pins reach decode two edges after sampling. */
`timescale 1ns/1ps
`default_nettype none
module dcs_sva
  import dcs_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_cke,
  input wire logic              i_cs_n,
  input wire logic              i_ras_n,
  input wire logic              i_cas_n,
  input wire logic              i_we_n,
  input wire logic [BA_W-1:0]   i_ba,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [ADDR_W-1:0] o_mode_config_word,
  input wire logic              o_strobe_single_ended,
  input wire logic [2:0]        o_write_recovery_clocks,
  input wire logic [1:0]        o_power_state,
  input wire logic              o_clk_change_ok,
  input wire logic              o_act_ready,
  input wire logic              o_spacing_violation
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // mode write seen at the pins with the clock enabled
  wire mode_pin = !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n && i_cke;
  a_strobe_bit: assert property (
    o_strobe_single_ended == o_mode_config_word[MODE_STROBE_BIT])
    else $error("strobe output differs from mode bit");
  a_wr_field: assert property (
    o_write_recovery_clocks ==
      o_mode_config_word[MODE_WR_MSB:MODE_WR_LSB])
    else $error("recovery field differs from mode word");
  a_clk_change: assert property (
    o_clk_change_ok ==
      (o_power_state inside {DCS_ST_PRE_PD, DCS_ST_SELF_REF}))
    else $error("clock change flag wrong for state");
  a_ready_state: assert property (
    o_act_ready |-> o_power_state == DCS_ST_ACTIVE)
    else $error("activate ready outside active state");
  a_exit_spacing: assert property (
    $past(o_power_state) == DCS_ST_PRE_PD &&
      o_power_state == DCS_ST_ACTIVE |-> !o_act_ready ##1 o_act_ready)
    else $error("exit spacing not two edges");
  a_mode_write: assert property (
    mode_pin && i_ba == BA_MODE && $past(i_cke) && $past(i_rst_n) &&
      o_power_state == DCS_ST_ACTIVE |->
      ##3 o_mode_config_word == $past(i_addr, 3))
    else $error("mode word not taken");
  a_mode_keep: assert property (
    mode_pin && i_ba != BA_MODE |-> ##3 $stable(o_mode_config_word))
    else $error("mode word changed by other bank");
  // pin edge at e reaches the state register at e+2, seen at e+3
  a_state_cause: assert property (
    $changed(o_power_state) |-> $past(i_cke, 3) != $past(i_cke, 4))
    else $error("power state moved without cke edge");
endmodule
bind dcs_spacing_tracker dcs_sva i_sva (.*);
`default_nettype wire

/* testbench/test_dcs_spacing_tracker.sv */
/* self-checking bench for the spacing tracker.
   assumes a 10 mhz clock and the cke pacer as controller model. */
`timescale 1ns/1ps
`default_nettype none
module test_dcs_spacing_tracker;
  import dcs_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, cke_req = 1'b1, cke;
  logic [3:0]  cmd = DCS_CMD_NOP;
  logic [1:0]  ba = 2'h0, st;
  logic [13:0] addr = 14'h0000, mode;
  logic [2:0]  wr;
  logic        se, ok, rdy, viol;
  int          fail_count = 0, tests_run = 0;
  dcs_ctrl_model i_ctrl (.i_clk(clk), .i_cke(cke_req), .o_cke(cke));
  dcs_spacing_tracker i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cke(cke),
    .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
    .i_ba(ba), .i_addr(addr), .o_mode_config_word(mode),
    .o_strobe_single_ended(se), .o_write_recovery_clocks(wr),
    .o_power_state(st), .o_clk_change_ok(ok), .o_act_ready(rdy),
    .o_spacing_violation(viol));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one command for one edge, then the address lines wander off;
  // returns while a one-cycle violation pulse still stands
  task automatic issue(input logic [3:0]  c,
                       input logic [1:0]  b,
                       input logic [13:0] a);
    cmd = c;
    ba = b;
    addr = a;
    @(negedge clk);
    cmd = DCS_CMD_NOP;
    addr = ~a;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_mode;
    logic [13:0] w[3] = '{14'h0400, 14'h0a00, 14'h0000};
    foreach (w[i]) begin
      issue(DCS_CMD_MODE, BA_MODE, w[i]);
      chk(mode, w[i]);
      chk(se, w[i][MODE_STROBE_BIT]);
      chk(wr, w[i][MODE_WR_MSB:MODE_WR_LSB]);
    end
    issue(DCS_CMD_MODE, 2'h1, 14'h0400);
    chk(se, 1'b0);
    $display("mode test done");
  endtask
  // power-down exit, then activate after lag edges
  task automatic t_pd(input int lag, input logic ev);
    cke_req = 1'b0;
    repeat (6) @(negedge clk);
    chk(st, DCS_ST_PRE_PD);
    chk(ok, 1'b1);
    cke_req = 1'b1;
    repeat (lag) @(negedge clk);
    issue(DCS_CMD_ACT, 2'h1, 14'h0000);
    chk(viol, ev);
    chk(st, DCS_ST_ACTIVE);
    issue(DCS_CMD_PRE, 2'h1, 14'h0400);
    $display("power-down test done");
  endtask
  task automatic t_self;
    cmd = DCS_CMD_REF;
    cke_req = 1'b0;
    @(negedge clk);
    cmd = DCS_CMD_NOP;
    repeat (6) @(negedge clk);
    chk(st, DCS_ST_SELF_REF);
    chk(ok, 1'b1);
    cke_req = 1'b1;
    repeat (8) @(negedge clk);
    chk(ok, 1'b0);
    $display("self refresh test done");
  endtask
  // reopen refused, precharge then activate on the very next edge
  task automatic t_bank;
    issue(DCS_CMD_ACT, 2'h0, 14'h0000);
    chk(viol, 1'b0);
    issue(DCS_CMD_ACT, 2'h0, 14'h0000);
    chk(viol, 1'b1);
    cmd = DCS_CMD_PRE;
    @(negedge clk);
    issue(DCS_CMD_ACT, 2'h0, 14'h0000);
    chk(viol, 1'b0);
    // write then read three edges apart, neither one flagged
    issue(DCS_CMD_WRITE, 2'h0, 14'h0000);
    chk(viol, 1'b0);
    issue(DCS_CMD_READ, 2'h0, 14'h0000);
    chk(viol, 1'b0);
    issue(DCS_CMD_PRE, 2'h0, 14'h0400);
    $display("bank test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(st, DCS_ST_ACTIVE);
    chk(rdy, 1'b1);
    chk(mode, MODE_RESET);
    t_mode();
    t_pd(1, 1'b1);
    t_pd(2, 1'b0);
    t_self();
    t_bank();
    close_out();
  end
endmodule
`default_nettype wire
